// >>> stbg_chk.sv
// Port-level assertions for the stereo tone generator
`timescale 1ns/100ps
module stbg_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        dac_processing_mode_25_i,
    input wire logic        sample_tick_i,
    input wire logic [15:0] tone_left_o,
    input wire logic [15:0] tone_right_o,
    input wire logic        tone_valid_o,
    input wire logic        tone_ready_i,
    input wire logic        tone_active_o
);
    // ------------------------------------------------------------------
    // Clocking and properties
    // ------------------------------------------------------------------
    // One clock domain, so clock and reset are given once for all checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_resv;
        rd_i && addr_i == 8'h47 |=> rdata_o[6] == 1'b0;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved bit of left control reads one");

    property p_left_vol;
        wr_i && addr_i == 8'h47 ##1 rd_i && !wr_i && addr_i == 8'h47
            |=> rdata_o[5:0] == $past(wdata_i[5:0], 2);
    endproperty
    a_left_vol: assert property (p_left_vol)
        else $error("left volume field does not read back");

    property p_right_ctl;
        wr_i && addr_i == 8'h48 ##1 rd_i && !wr_i && addr_i == 8'h48
            |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_right_ctl: assert property (p_right_ctl)
        else $error("right control does not read back");

    // Length and coefficient bytes are plain storage
    property p_len_coef;
        wr_i && addr_i >= 8'h49 && addr_i <= 8'h4f ##1 rd_i && !wr_i && addr_i == $past(addr_i)
            |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_len_coef: assert property (p_len_coef)
        else $error("length or coefficient byte does not read back");

    property p_no_mode;
        !dac_processing_mode_25_i [*6] |-> !tone_active_o;
    endproperty
    a_no_mode: assert property (p_no_mode)
        else $error("generator active outside processing mode 25");

    // Two sync flops, the state register and the output flop: mode was high four clocks back
    property p_mode_start;
        $rose(tone_active_o) |-> $past(dac_processing_mode_25_i, 4);
    endproperty
    a_mode_start: assert property (p_mode_start)
        else $error("generator started without processing mode 25");

    property p_valid_hold;
        tone_valid_o && !tone_ready_i |=> tone_valid_o;
    endproperty
    a_valid_hold: assert property (p_valid_hold)
        else $error("tone word withdrawn before acceptance");

    property p_data_hold;
        tone_valid_o && !tone_ready_i |=> $stable(tone_left_o) && $stable(tone_right_o);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("tone word changed while stalled");
endmodule : stbg_chk

bind stbg_top stbg_chk chk_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .dac_processing_mode_25_i, .sample_tick_i, .tone_left_o, .tone_right_o, .tone_valid_o,
    .tone_ready_i, .tone_active_o);

// >>> stbg_dac_model.sv
// Behavioural DAC playback path: sample ticks and tone word acceptance
`timescale 1ns/100ps
module stbg_dac_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic stall_i,
    input  wire logic slow_i,
    output logic      sample_tick_o,
    output logic      tone_ready_o
);
    logic [3:0] cnt_r;
    logic       ph_r;

    // ------------------------------------------------------------------
    // Sample clock and consumer
    // ------------------------------------------------------------------
    // Twelve system clocks a sample keeps ticks well over eight apart
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
            ph_r  <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 4'hb) ? 4'h0 : cnt_r + 4'h1;
            ph_r  <= ~ph_r;
        end
    end

    // Slow mode takes a word every other cycle; a stall lets the FIFO fill
    assign sample_tick_o = (cnt_r < 4'h6);
    assign tone_ready_o  = !stall_i && (!slow_i || ph_r);
endmodule : stbg_dac_model

// >>> stbg_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module stbg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    // Honest full and empty from the occupancy count
    assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rptr_r];

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end else begin
            if (push) wptr_r <= wptr_r + 1'b1;
            if (pop)  rptr_r <= rptr_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule : stbg_fifo

// >>> stbg_pkg.sv
// Package for the stereo tone generator: register map, field layout, types
package stbg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LEFT_CTRL    = 8'h47;
    localparam logic [7:0] ADDR_RIGHT_CTRL   = 8'h48;
    localparam logic [7:0] ADDR_LEN_HIGH     = 8'h49;
    localparam logic [7:0] ADDR_LEN_MID      = 8'h4a;
    localparam logic [7:0] ADDR_LEN_LOW      = 8'h4b;
    localparam logic [7:0] ADDR_SIN_HIGH     = 8'h4c;
    localparam logic [7:0] ADDR_SIN_LOW      = 8'h4d;
    localparam logic [7:0] ADDR_COS_HIGH     = 8'h4e;
    localparam logic [7:0] ADDR_COS_LOW      = 8'h4f;
    localparam logic [7:0] ADDR_STATUS       = 8'h40;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_LEFT_CTRL     = 8'h00;
    localparam logic [7:0] RST_RIGHT_CTRL    = 8'h00;
    localparam logic [7:0] RST_LEN_HIGH      = 8'h00;
    localparam logic [7:0] RST_LEN_MID       = 8'h00;
    localparam logic [7:0] RST_LEN_LOW       = 8'hee;
    localparam logic [7:0] RST_SIN_HIGH      = 8'h10;
    localparam logic [7:0] RST_SIN_LOW       = 8'hd8;
    localparam logic [7:0] RST_COS_HIGH      = 8'h7e;
    localparam logic [7:0] RST_COS_LOW       = 8'he3;

    // ------------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------------
    localparam int         BIT_ENABLE        = 7;
    localparam int         BIT_RESV          = 6;
    localparam int         VOL_W             = 6;
    localparam logic [1:0] CPL_R_TO_L        = 2'h1;
    localparam logic [1:0] CPL_L_TO_R        = 2'h2;
    localparam logic [7:0] VOL_MASK          = 8'h3f;
    localparam logic [7:0] RESV_MASK         = 8'hbf;
    localparam int         GAIN_W            = 16;
    localparam int         LEN_W             = 24;
    localparam int         COEF_W            = 16;
    localparam int         SAMP_W            = 16;
    localparam int         FIFO_DEPTH        = 16;
    localparam logic [15:0] SAMP_ZERO        = 16'h0000;
    localparam logic [23:0] LEN_ZERO         = 24'h000000;

    // Stereo tone sample carried through the FIFO
    typedef struct packed {
        logic [SAMP_W-1:0] left;
        logic [SAMP_W-1:0] right;
    } stbg_sample_t;

    // Oscillator state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CALC,
        ST_PUSH
    } stbg_state_t;

endpackage : stbg_pkg

// >>> stbg_top.sv
// Stereo tone generator: registers, recursive sine oscillator, gain, output FIFO
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module stbg_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        dac_processing_mode_25_i,
    input  wire logic        sample_tick_i,
    output logic      [15:0] tone_left_o,
    output logic      [15:0] tone_right_o,
    output logic             tone_valid_o,
    input  wire logic        tone_ready_i,
    output logic             tone_active_o
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0]  left_ctrl_r;
    logic [7:0]  right_ctrl_r;
    logic [7:0]  len_high_r;
    logic [7:0]  len_mid_r;
    logic [7:0]  len_low_r;
    logic [7:0]  sin_high_r;
    logic [7:0]  sin_low_r;
    logic [7:0]  cos_high_r;
    logic [7:0]  cos_low_r;
    logic        clear_en;

    // Write decode as named wires
    wire wr_left  = wr_i && (addr_i == stbg_pkg::ADDR_LEFT_CTRL);
    wire wr_right = wr_i && (addr_i == stbg_pkg::ADDR_RIGHT_CTRL);
    wire wr_lenh  = wr_i && (addr_i == stbg_pkg::ADDR_LEN_HIGH);
    wire wr_lenm  = wr_i && (addr_i == stbg_pkg::ADDR_LEN_MID);
    wire wr_lenl  = wr_i && (addr_i == stbg_pkg::ADDR_LEN_LOW);
    wire wr_sinh  = wr_i && (addr_i == stbg_pkg::ADDR_SIN_HIGH);
    wire wr_sinl  = wr_i && (addr_i == stbg_pkg::ADDR_SIN_LOW);
    wire wr_cosh  = wr_i && (addr_i == stbg_pkg::ADDR_COS_HIGH);
    wire wr_cosl  = wr_i && (addr_i == stbg_pkg::ADDR_COS_LOW);

    // Reserved bit kept at its reset value whatever software writes
    wire [7:0] left_wr_val = wdata_i & stbg_pkg::RESV_MASK;

    // Enable: a software write in the same cycle as the end of the tone wins,
    // so a fresh start is never lost to the self-clear.
    logic [7:0] left_nxt;
    always_comb begin
        left_nxt = left_ctrl_r;
        if (clear_en) begin
            left_nxt[stbg_pkg::BIT_ENABLE] = 1'b0;
        end
        if (wr_left) begin
            left_nxt = left_wr_val;
        end
    end

    // Storage for all nine control registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            left_ctrl_r  <= stbg_pkg::RST_LEFT_CTRL;
            right_ctrl_r <= stbg_pkg::RST_RIGHT_CTRL;
            len_high_r   <= stbg_pkg::RST_LEN_HIGH;
            len_mid_r    <= stbg_pkg::RST_LEN_MID;
            len_low_r    <= stbg_pkg::RST_LEN_LOW;
            sin_high_r   <= stbg_pkg::RST_SIN_HIGH;
            sin_low_r    <= stbg_pkg::RST_SIN_LOW;
            cos_high_r   <= stbg_pkg::RST_COS_HIGH;
            cos_low_r    <= stbg_pkg::RST_COS_LOW;
        end else begin
            left_ctrl_r <= left_nxt;
            if (wr_right) right_ctrl_r <= wdata_i;
            if (wr_lenh)  len_high_r   <= wdata_i;
            if (wr_lenm)  len_mid_r    <= wdata_i;
            if (wr_lenl)  len_low_r    <= wdata_i;
            if (wr_sinh)  sin_high_r   <= wdata_i;
            if (wr_sinl)  sin_low_r    <= wdata_i;
            if (wr_cosh)  cos_high_r   <= wdata_i;
            if (wr_cosl)  cos_low_r    <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] status_val;

    always_comb begin
        case (addr_i)
            stbg_pkg::ADDR_LEFT_CTRL:  rd_mux = left_ctrl_r;
            stbg_pkg::ADDR_RIGHT_CTRL: rd_mux = right_ctrl_r;
            stbg_pkg::ADDR_LEN_HIGH:   rd_mux = len_high_r;
            stbg_pkg::ADDR_LEN_MID:    rd_mux = len_mid_r;
            stbg_pkg::ADDR_LEN_LOW:    rd_mux = len_low_r;
            stbg_pkg::ADDR_SIN_HIGH:   rd_mux = sin_high_r;
            stbg_pkg::ADDR_SIN_LOW:    rd_mux = sin_low_r;
            stbg_pkg::ADDR_COS_HIGH:   rd_mux = cos_high_r;
            stbg_pkg::ADDR_COS_LOW:    rd_mux = cos_low_r;
            stbg_pkg::ADDR_STATUS:     rd_mux = status_val;
            default:                   rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Synchronise the pin-level inputs
    // ------------------------------------------------------------------
    logic [1:0] mode_sync_r;
    logic [1:0] tick_sync_r;
    logic       tick_prev_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_sync_r <= 2'h0;
            tick_sync_r <= 2'h0;
            tick_prev_r <= 1'b0;
        end else begin
            mode_sync_r <= {mode_sync_r[0], dac_processing_mode_25_i};
            tick_sync_r <= {tick_sync_r[0], sample_tick_i};
            tick_prev_r <= tick_sync_r[1];
        end
    end
    wire mode_ok   = mode_sync_r[1];
    wire tick_rise = tick_sync_r[1] & ~tick_prev_r;

    // ------------------------------------------------------------------
    // Gain selection
    // ------------------------------------------------------------------
    wire [1:0] couple  = right_ctrl_r[7:6];
    wire [5:0] vol_l   = left_ctrl_r[stbg_pkg::VOL_W-1:0];
    wire [5:0] vol_r   = right_ctrl_r[stbg_pkg::VOL_W-1:0];
    // Right gain to both for 01, left to both for 10, else independent
    wire [5:0] code_l  = (couple == stbg_pkg::CPL_R_TO_L) ? vol_r : vol_l;
    wire [5:0] code_r  = (couple == stbg_pkg::CPL_L_TO_R) ? vol_l : vol_r;

    // Gain in Q1.15 with headroom: 1 dB steps from +2 dB.
    // Six 1 dB fractions and a right shift per 6 dB keep the table small;
    // each shift is a true halving, so the deepest codes sit a fraction of a dB low.
    function automatic logic [15:0] stbg_gain(input logic [5:0] code);
        logic [15:0] mant;
        logic [2:0]  frac;
        logic [3:0]  oct;
        begin
            // code = 6*oct + frac, each 6 dB halves the gain
            oct  = 4'(code / 6'd6);
            frac = 3'(code % 6'd6);
            case (frac)
                3'h0:    mant = 16'h50c3;  // +2 dB at half scale headroom
                3'h1:    mant = 16'h47cf;  // +1 dB
                3'h2:    mant = 16'h4000;  //  0 dB
                3'h3:    mant = 16'h3906;  // -1 dB
                3'h4:    mant = 16'h32f5;  // -2 dB
                3'h5:    mant = 16'h2d6a;  // -3 dB
                default: mant = 16'h0000;
            endcase
            stbg_gain = mant >> oct;
        end
    endfunction : stbg_gain

    wire [15:0] gain_l = stbg_gain(code_l);
    wire [15:0] gain_r = stbg_gain(code_r);

    // ------------------------------------------------------------------
    // Oscillator: y[n] = 2*cos*y[n-1] - y[n-2], seeded with y1 = sin
    // ------------------------------------------------------------------
    wire signed [15:0] sin_c  = {sin_high_r, sin_low_r};
    wire signed [15:0] cos_c  = {cos_high_r, cos_low_r};
    wire [23:0]        length = {len_high_r, len_mid_r, len_low_r};
    wire               enable = left_ctrl_r[stbg_pkg::BIT_ENABLE];

    stbg_pkg::stbg_state_t state_r;
    logic signed [15:0] y1_r;
    logic signed [15:0] y2_r;
    logic [23:0]        remain_r;
    stbg_pkg::stbg_sample_t samp_r;
    logic               push_r;
    logic               fifo_ready;

    // Recursion product: cos is Q1.15, so 2*cos*y needs a shift of 14
    wire signed [31:0] prod    = cos_c * y1_r;
    wire signed [17:0] next_w  = 18'(prod >>> 14) - 18'(y2_r);
    wire signed [15:0] y0      = (next_w > 18'sd32767)  ? 16'sh7fff :
                                 (next_w < -18'sd32768) ? 16'sh8000 : next_w[15:0];
    wire signed [31:0] mul_l   = y0 * $signed({1'b0, gain_l[14:0]});
    wire signed [31:0] mul_r   = y0 * $signed({1'b0, gain_r[14:0]});

    assign clear_en = (state_r == stbg_pkg::ST_PUSH) && fifo_ready &&
                      (remain_r == 24'h000001);

    // ------------------------------------------------------------------
    // Sequencer: one tone sample per DAC sample tick
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r  <= stbg_pkg::ST_IDLE;
            y1_r     <= stbg_pkg::SAMP_ZERO;
            y2_r     <= stbg_pkg::SAMP_ZERO;
            remain_r <= stbg_pkg::LEN_ZERO;
            samp_r   <= '0;
            push_r   <= 1'b0;
        end else begin
            case (state_r)
                stbg_pkg::ST_IDLE: begin
                    push_r <= 1'b0;
                    // Arm: load the count and seed the oscillator
                    if (enable && mode_ok && length != 24'h000000) begin
                        remain_r <= length;
                        y1_r     <= sin_c;
                        y2_r     <= stbg_pkg::SAMP_ZERO;
                        state_r  <= stbg_pkg::ST_CALC;
                    end
                end
                stbg_pkg::ST_CALC: begin
                    if (!enable || !mode_ok) begin
                        state_r <= stbg_pkg::ST_IDLE;
                    end else if (tick_rise) begin
                        samp_r.left  <= mul_l[30:15];
                        samp_r.right <= mul_r[30:15];
                        y2_r         <= y1_r;
                        y1_r         <= y0;
                        push_r       <= 1'b1;
                        state_r      <= stbg_pkg::ST_PUSH;
                    end
                end
                stbg_pkg::ST_PUSH: begin
                    // Hold the sample until the FIFO takes it; a stalled FIFO
                    // must not keep the tone alive once enable or mode drops
                    if (!enable || !mode_ok) begin
                        push_r  <= 1'b0;
                        state_r <= stbg_pkg::ST_IDLE;
                    end else if (fifo_ready) begin
                        push_r   <= 1'b0;
                        remain_r <= remain_r - 24'h000001;
                        state_r  <= (remain_r == 24'h000001) ? stbg_pkg::ST_IDLE
                                                             : stbg_pkg::ST_CALC;
                    end
                end
                default: state_r <= stbg_pkg::ST_IDLE;
            endcase
        end
    end

    assign status_val = {7'h00, state_r != stbg_pkg::ST_IDLE};

    // ------------------------------------------------------------------
    // Output FIFO towards the playback path
    // ------------------------------------------------------------------
    stbg_pkg::stbg_sample_t fifo_out;
    logic                   fifo_valid;
    stbg_fifo #(
        .WIDTH (2 * stbg_pkg::SAMP_W),
        .DEPTH (stbg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (samp_r),
        .in_valid_i  (push_r),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_valid),
        .out_ready_i (tone_ready_i & ~tone_valid_o)
    );

    // Registered output stage; one word held until taken
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tone_left_o   <= stbg_pkg::SAMP_ZERO;
            tone_right_o  <= stbg_pkg::SAMP_ZERO;
            tone_valid_o  <= 1'b0;
            tone_active_o <= 1'b0;
        end else begin
            tone_active_o <= (state_r != stbg_pkg::ST_IDLE);
            if (tone_valid_o && tone_ready_i) begin
                tone_valid_o <= 1'b0;
            end else if (!tone_valid_o && fifo_valid && tone_ready_i) begin
                tone_left_o  <= fifo_out.left;
                tone_right_o <= fifo_out.right;
                tone_valid_o <= 1'b1;
            end
        end
    end

endmodule : stbg_top

// >>> test_stereo_beep_tone_generator.sv
// Self-checking testbench for the stereo tone generator
`timescale 1ns/100ps
module test_stereo_beep_tone_generator;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        dac_processing_mode_25_i = 1'b0;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    logic        rd_d = 1'b0;
    logic [31:0] seed = 32'h00000011;
    wire  [7:0]  rdata_o;
    wire  [15:0] tone_left_o;
    wire  [15:0] tone_right_o;
    wire         tone_valid_o;
    wire         tone_ready_i;
    wire         tone_active_o;
    wire         sample_tick_i;
    int          fails = 0;
    int          num_checks = 0;
    logic [7:0]  rd_q[$];
    int          kind_q[$];
    logic [7:0]  rst_tab [9] = '{stbg_pkg::RST_LEFT_CTRL, stbg_pkg::RST_RIGHT_CTRL,
        stbg_pkg::RST_LEN_HIGH, stbg_pkg::RST_LEN_MID, stbg_pkg::RST_LEN_LOW,
        stbg_pkg::RST_SIN_HIGH, stbg_pkg::RST_SIN_LOW, stbg_pkg::RST_COS_HIGH,
        stbg_pkg::RST_COS_LOW};

    stbg_top dut_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .dac_processing_mode_25_i, .sample_tick_i, .tone_left_o, .tone_right_o,
        .tone_valid_o, .tone_ready_i, .tone_active_o);
    stbg_dac_model dac_u (.clk_i, .rst_i, .stall_i(stall), .slow_i(slow),
        .sample_tick_o(sample_tick_i), .tone_ready_o(tone_ready_i));

    // 50 MHz system clock
    always #10 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic print_verdict;
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask : chk1

    // Bus strobes change only just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
        addr_i  <= a;
        wdata_i <= d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_q.push_back(e);
        rd_i   <= 1'b1;
        wr_i   <= 1'b0;
        addr_i <= a;
    endtask : rd

    task automatic idle(input int n);
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : idle

    // Bounded wait on the activity flag, sampled away from the edge
    task automatic wait_act(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && tone_active_o !== lvl; i++) @(negedge clk_i);
        if (tone_active_o !== lvl) begin
            chk1("tone_active", lvl, tone_active_o);
            print_verdict();
        end
    endtask : wait_act

    // One beep of n samples; each word must show the relation given by k
    task automatic play(input logic [7:0] lc, input logic [7:0] rc, input int n, input int k);
        int i;
        wr(8'h49, 8'h00);
        wr(8'h4a, 8'h00);
        wr(8'h4b, n[7:0]);
        wr(8'h48, rc);
        for (i = 0; i < n; i++) kind_q.push_back(k);
        wr(8'h47, lc | 8'h80);
        idle(0);
        wait_act(1'b1, 40);
        rd(8'h40, 8'h01);
        idle(0);
        wait_act(1'b0, 400);
        rd(8'h47, lc & 8'h3f);
        idle(0);
    endtask : play

    // ------------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------------
    // Takes the oldest note whenever read data or a tone word appears
    always @(posedge clk_i) begin : mon
        int k;
        int d;
        rd_d <= rd_i;
        if (rd_d)
            chk8("rdata", (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx, rdata_o);
        if (!rst_i && tone_valid_o && tone_ready_i) begin
            k = (kind_q.size() > 0) ? kind_q.pop_front() : 2;
            d = $signed(tone_left_o) - 2 * $signed(tone_right_o);
            if (k == 0)
                chk1("equal_gain", 1'b1,
                     tone_left_o === tone_right_o && tone_left_o != 16'h0);
            else if (k == 1)
                chk1("double_gain", 1'b1,
                     d <= 4 && d >= -4 && tone_right_o != 16'h0);
            else
                chk1("extra_word", 1'b0, 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin : main
        int i;
        logic [7:0] v;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 9; i++) rd(8'h47 + i[7:0], rst_tab[i]);
        rd(8'h40, 8'h00);
        rd(8'h50, 8'h00);
        // Random bytes, each read back at once; left keeps enable and bit 6 clear
        for (i = 0; i < 9; i++) begin
            v = (i == 0) ? (rnd() & 8'h3f) : rnd();
            wr(8'h47 + i[7:0], v);
            rd(8'h47 + i[7:0], (i == 0) ? (v & 8'h3f) : v);
        end
        for (i = 5; i < 9; i++) wr(8'h47 + i[7:0], rst_tab[i]);
        // Enabled outside mode 25: no word and no activity
        wr(8'h4b, 8'h03);
        wr(8'h47, 8'h80);
        idle(100);
        @(negedge clk_i);
        chk1("tone_active", 1'b0, tone_active_o);
        wr(8'h47, 8'h00);
        dac_processing_mode_25_i <= 1'b1;
        idle(4);
        // Every coupling code; left code 0 is 6 dB above right code 6
        for (i = 0; i < 4; i++) begin
            slow <= i[0];
            play(8'h00, {i[1:0], 6'h06}, 3 + int'(rnd() & 8'h03), (i == 1 || i == 2) ? 0 : 1);
            idle(60);
            chk1("word_count", 1'b1, kind_q.size() == 0);
        end
        // Consumer stalls until all sixteen words sit in the FIFO
        stall <= 1'b1;
        play(8'h06, 8'h06, 16, 0);
        stall <= 1'b0;
        // Slow consumer needs four cycles a word to drain sixteen
        idle(100);
        chk1("word_count", 1'b1, kind_q.size() == 0);
        print_verdict();
    end
endmodule : test_stereo_beep_tone_generator
